/* File: core/vsim_top.sv */
// Purpose: VMEbus slave inbound map: decode, scatter-gather translate, monitors
// Assumes: VMEbus lines are asynchronous; PCI and register port share CLOCK
// Notes: Register reads answer one cycle after REG_RD
`timescale 1ns/1ps
`default_nettype none
`include "vsim_regs.svh"
module vsim_top #(
  parameter int A32_ENTRIES = 16384,
  parameter int A24_ENTRIES = 2048,
  parameter logic [7:0] IPC_REVISION = 8'h5a // Arbitrary value
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [11:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_WDATA,
  output logic [31:0] REG_RDATA,
  input wire logic [31:0] VME_ADDR,
  input wire logic [5:0] VME_AM,
  input wire logic VME_AS_N,
  input wire logic [1:0] VME_DS_N,
  input wire logic VME_LWORD_N,
  input wire logic VME_WRITE_N,
  input wire logic [7:0] VME_DATA_IN,
  output logic VME_DTACK_N,
  output logic VME_BERR_N,
  output logic [7:0] VME_DATA_OUT,
  output logic VME_DATA_OE,
  output logic PCI_REQ,
  output logic [31:0] PCI_ADDR,
  output logic [3:0] PCI_CMD,
  output logic [3:0] PCI_BE_N,
  input wire logic PCI_ACK,
  output logic LOCAL_IRQ,
  input wire logic MASTER_WANT,
  input wire logic VME_BG_N,
  output logic [3:0] VME_BR_N,
  output logic MASTER_GRANTED
);

  localparam int I32W = $clog2(A32_ENTRIES);
  localparam int I24W = $clog2(A24_ENTRIES);

  // Pin synchronisers: two flops before anything looks at the VMEbus
  vsim_pkg::vsim_vme_in_t vin_meta_r, vin_s_r;
  logic bg_meta_r, bg_s_r;
  logic as_prev_r;

  // Cycle state
  vsim_pkg::vsim_state_t st_r, st_nxt;
  vsim_pkg::vsim_vme_in_t cyc_r, cyc_nxt;
  logic [31:0] ent_r, ent_nxt;
  logic a24_r, a24_nxt;
  logic dtack_r, dtack_nxt, berr_r, berr_nxt;
  logic [7:0] dout_r, dout_nxt;
  logic oe_r, oe_nxt;
  logic preq_r, preq_nxt;
  vsim_pkg::vsim_pci_req_t pci_r, pci_nxt;
  logic [2:0] bump;

  // Software registers
  logic [31:0] mask_r, mask_nxt, base_r, base_nxt;
  logic [15:0] sgidx_r, sgidx_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic besr_r, besr_nxt, icr_r, icr_nxt, irq_r, irq_nxt;
  logic [3:0] arb_r, arb_nxt;
  logic [3:0] br_r, br_nxt;
  logic gnt_r, gnt_nxt;

  // Monitors and communication registers
  logic [2:0] cnt_r [3];
  logic [2:0] cnt_nxt [3];
  logic [2:0] ovf_r, ovf_nxt, ovf_evt;
  logic [7:0] gp_r [5];
  logic [7:0] gp_nxt [5];
  logic [4:0] wflag_r, wflag_nxt;

  // Scatter-gather tables in flip-flops
  logic [31:0] sg32_r [A32_ENTRIES];
  logic [31:0] sg24_r [A24_ENTRIES];

  logic hit32, hit24, hit16, sup;
  logic pg_wr, cnt_wr;
  logic [I32W-1:0] idx32;
  logic [I24W-1:0] idx24;
  logic [2:0] gpi;
  logic as_fall;

  vsim_space_match u_match (
    .addr(cyc_r.addr),
    .am(cyc_r.am),
    .base(base_r),
    .mask(mask_r),
    .hit32(hit32),
    .hit24(hit24),
    .hit16(hit16),
    .super_cyc(sup)
  );

  // Page index straight from the address above the 8 KB offset
  assign idx32 = cyc_r.addr[13 +: I32W];
  assign idx24 = cyc_r.addr[13 +: I24W];
  assign gpi = cyc_r.addr[3:1];
  assign as_fall = as_prev_r && !vin_s_r.as_n;
  assign pg_wr = REG_WR && (REG_ADDR == `VSIM_OFS_SG_DATA);
  assign cnt_wr = REG_WR && (REG_ADDR == `VSIM_OFS_PAGE_CNT);

  // Slave cycle sequencer
  always_comb begin
    st_nxt = st_r;
    cyc_nxt = cyc_r;
    ent_nxt = ent_r;
    a24_nxt = a24_r;
    dtack_nxt = dtack_r;
    berr_nxt = berr_r;
    dout_nxt = dout_r;
    oe_nxt = oe_r;
    preq_nxt = preq_r;
    pci_nxt = pci_r;
    bump = 3'h0;
    for (int i = 0; i < 5; i++) begin
      gp_nxt[i] = gp_r[i];
    end
    wflag_nxt = wflag_r;
    case (st_r)
      vsim_pkg::ST_IDLE: begin
        if (as_fall) begin
          cyc_nxt = vin_s_r;
          st_nxt = vsim_pkg::ST_DECODE;
        end
      end
      vsim_pkg::ST_DECODE: begin
        // Hits are exclusive: each space decodes its own address modifier codes
        if (hit32) begin
          ent_nxt = sg32_r[idx32];
          a24_nxt = 1'b0;
          st_nxt = vsim_pkg::ST_CHECK;
        end else if (hit24) begin
          ent_nxt = sg24_r[idx24];
          a24_nxt = 1'b1;
          st_nxt = vsim_pkg::ST_CHECK;
        end else if (hit16) begin
          st_nxt = vsim_pkg::ST_A16;
        end else begin
          st_nxt = vsim_pkg::ST_WAITEND; // Not ours: stay silent
        end
      end
      vsim_pkg::ST_CHECK: begin
        if (!ent_r[`VSIM_SG_VALID]
            || (ent_r[`VSIM_SG_WLOCK] && !cyc_r.write_n)
            || (ent_r[`VSIM_SG_SUPER] && !sup)) begin
          berr_nxt = 1'b1;
        end else begin
          preq_nxt = 1'b1;
          pci_nxt.addr = {1'b0,
                          ent_r[`VSIM_SG_PAGE_HI:`VSIM_SG_PAGE_LO],
                          cyc_r.addr[12:2], 2'b00};
          // Only memory or I/O codes exist here, so no configuration cycle
          if (ent_r[`VSIM_SG_IOSEL]) begin
            pci_nxt.cmd = cyc_r.write_n ? `VSIM_CMD_IORD : `VSIM_CMD_IOWR;
          end else begin
            pci_nxt.cmd = cyc_r.write_n ? `VSIM_CMD_MEMRD : `VSIM_CMD_MEMWR;
          end
          if (!cyc_r.lword_n) begin
            pci_nxt.be_n = 4'h0;
          end else if (cyc_r.addr[1]) begin
            pci_nxt.be_n = {cyc_r.ds_n[0], cyc_r.ds_n[1], 2'h3};
          end else begin
            pci_nxt.be_n = {2'h3, cyc_r.ds_n[0], cyc_r.ds_n[1]};
          end
          case (ent_r[`VSIM_SG_MON_HI:`VSIM_SG_MON_LO])
            2'h1: bump = 3'h1;
            2'h2: bump = 3'h2;
            2'h3: bump = 3'h4;
            default: bump = 3'h0;
          endcase
        end
        st_nxt = berr_nxt ? vsim_pkg::ST_WAITEND : vsim_pkg::ST_PCI;
      end
      vsim_pkg::ST_PCI: begin
        if (PCI_ACK) begin
          preq_nxt = 1'b0;
          dtack_nxt = 1'b1;
          st_nxt = vsim_pkg::ST_WAITEND;
        end
      end
      vsim_pkg::ST_A16: begin
        // Odd offsets 01..09 are the general byte registers
        if (cyc_r.addr[7:4] == 4'h0 && cyc_r.addr[0] && gpi <= `VSIM_IPC_GP_LAST) begin
          if (!cyc_r.write_n) begin
            gp_nxt[gpi] = cyc_r.data;
            wflag_nxt[gpi] = 1'b1;
          end else begin
            dout_nxt = gp_r[gpi];
          end
        end else if (cyc_r.addr[7:0] == `VSIM_IPC_REV) begin
          dout_nxt = IPC_REVISION;
        end else if (cyc_r.addr[7:0] == `VSIM_IPC_WFLAG) begin
          if (!cyc_r.write_n) begin
            wflag_nxt = 5'h00; // Any write clears the write flags
          end else begin
            dout_nxt = {3'h0, wflag_r};
          end
        end else begin
          dout_nxt = `VSIM_RST_BYTE; // Status and unused offsets read zero
        end
        oe_nxt = cyc_r.write_n;
        dtack_nxt = 1'b1;
        st_nxt = vsim_pkg::ST_WAITEND;
      end
      vsim_pkg::ST_WAITEND: begin
        // Hold the answer until the master lets go of the strobe
        if (vin_s_r.as_n) begin
          dtack_nxt = 1'b0;
          berr_nxt = 1'b0;
          oe_nxt = 1'b0;
          st_nxt = vsim_pkg::ST_IDLE;
        end
      end
      default: begin
        st_nxt = vsim_pkg::ST_IDLE;
      end
    endcase
  end

  // Page monitors: a hit bumps the chosen counter, wrapping sets its flag
  generate
    for (genvar m = 0; m < 3; m++) begin : g_mon
      always_comb begin
        cnt_nxt[m] = bump[m] ? cnt_r[m] + 3'h1 : cnt_r[m];
        ovf_evt[m] = bump[m] && (cnt_r[m] == 3'h7);
        // Set beats a simultaneous write-one clear so no overflow is lost
        ovf_nxt[m] = ovf_evt[m] || (ovf_r[m] && !(cnt_wr && REG_WDATA[4*m+3]));
      end
    end
  endgenerate

  // Software registers, status and bus request
  always_comb begin
    mask_nxt = mask_r;
    base_nxt = base_r;
    sgidx_nxt = sgidx_r;
    icr_nxt = icr_r;
    arb_nxt = arb_r;
    besr_nxt = besr_r;
    if (REG_WR) begin
      case (REG_ADDR)
        `VSIM_OFS_MATCH_MASK: mask_nxt = REG_WDATA;
        `VSIM_OFS_BASE_MATCH: base_nxt = REG_WDATA;
        `VSIM_OFS_SG_INDEX: sgidx_nxt = REG_WDATA[15:0];
        `VSIM_OFS_IRQ_CTRL: icr_nxt = REG_WDATA[`VSIM_ICR_OVF];
        `VSIM_OFS_ARB_CFG: arb_nxt = REG_WDATA[3:0];
        `VSIM_OFS_BUS_ERR: besr_nxt = besr_r && !REG_WDATA[`VSIM_BESR_OVF];
        default: ;
      endcase
    end
    if (|ovf_evt) begin
      besr_nxt = 1'b1;
    end
    irq_nxt = besr_r && icr_r;
    rdata_nxt = rdata_r;
    if (REG_RD) begin
      case (REG_ADDR)
        `VSIM_OFS_MATCH_MASK: rdata_nxt = mask_r;
        `VSIM_OFS_BASE_MATCH: rdata_nxt = base_r;
        `VSIM_OFS_SG_INDEX: rdata_nxt = {16'h0000, sgidx_r};
        `VSIM_OFS_SG_DATA: rdata_nxt = sgidx_r[`VSIM_IDX_A24_SEL] ?
            sg24_r[sgidx_r[I24W-1:0]] : sg32_r[sgidx_r[I32W-1:0]];
        `VSIM_OFS_PAGE_CNT: rdata_nxt = {20'h00000, ovf_r[2], cnt_r[2], ovf_r[1], cnt_r[1],
            ovf_r[0], cnt_r[0]};
        `VSIM_OFS_BUS_ERR: rdata_nxt = {31'h0, besr_r};
        `VSIM_OFS_IRQ_CTRL: rdata_nxt = {31'h0, icr_r};
        `VSIM_OFS_ARB_CFG: rdata_nxt = {28'h0000000, arb_r};
        default: rdata_nxt = `VSIM_RST_WORD;
      endcase
    end
    // Request on the configured level only while master work is pending
    br_nxt = 4'hf;
    if (MASTER_WANT && !gnt_r) begin
      br_nxt[arb_r[1:0]] = 1'b0;
    end
    gnt_nxt = MASTER_WANT && !bg_s_r;
  end

  // Synchronisers and edge history
  always_ff @(posedge CLOCK) begin
    vin_meta_r <= {VME_ADDR, VME_AM, VME_AS_N, VME_DS_N, VME_LWORD_N, VME_WRITE_N, VME_DATA_IN};
    vin_s_r <= vin_meta_r;
    bg_meta_r <= VME_BG_N;
    bg_s_r <= bg_meta_r;
    as_prev_r <= RST_N ? vin_s_r.as_n : 1'b1;
  end

  // Table writes through the index/data pair
  always_ff @(posedge CLOCK) begin
    if (pg_wr && sgidx_r[`VSIM_IDX_A24_SEL]) begin
      sg24_r[sgidx_r[I24W-1:0]] <= REG_WDATA;
    end
    if (pg_wr && !sgidx_r[`VSIM_IDX_A24_SEL]) begin
      sg32_r[sgidx_r[I32W-1:0]] <= REG_WDATA;
    end
  end

  // State registers
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      st_r <= vsim_pkg::ST_IDLE;
      cyc_r <= '0;
      ent_r <= `VSIM_RST_WORD;
      a24_r <= 1'b0;
      dtack_r <= 1'b0;
      berr_r <= 1'b0;
      dout_r <= `VSIM_RST_BYTE;
      oe_r <= 1'b0;
      preq_r <= 1'b0;
      pci_r <= '0;
      mask_r <= `VSIM_RST_WORD;
      base_r <= `VSIM_RST_WORD;
      sgidx_r <= 16'h0000;
      rdata_r <= `VSIM_RST_WORD;
      besr_r <= 1'b0;
      icr_r <= 1'b0;
      irq_r <= 1'b0;
      arb_r <= 4'h0;
      br_r <= 4'hf;
      gnt_r <= 1'b0;
      ovf_r <= 3'h0;
      wflag_r <= 5'h00;
      for (int i = 0; i < 3; i++) begin
        cnt_r[i] <= 3'h0;
      end
      for (int i = 0; i < 5; i++) begin
        gp_r[i] <= `VSIM_RST_BYTE;
      end
    end else begin
      st_r <= st_nxt;
      cyc_r <= cyc_nxt;
      ent_r <= ent_nxt;
      a24_r <= a24_nxt;
      dtack_r <= dtack_nxt;
      berr_r <= berr_nxt;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
      preq_r <= preq_nxt;
      pci_r <= pci_nxt;
      mask_r <= mask_nxt;
      base_r <= base_nxt;
      sgidx_r <= sgidx_nxt;
      rdata_r <= rdata_nxt;
      besr_r <= besr_nxt;
      icr_r <= icr_nxt;
      irq_r <= irq_nxt;
      arb_r <= arb_nxt;
      br_r <= br_nxt;
      gnt_r <= gnt_nxt;
      ovf_r <= ovf_nxt;
      wflag_r <= wflag_nxt;
      cnt_r <= cnt_nxt;
      gp_r <= gp_nxt;
    end
  end

  assign REG_RDATA = rdata_r;
  assign VME_DTACK_N = !dtack_r;
  assign VME_BERR_N = !berr_r;
  assign VME_DATA_OUT = dout_r;
  assign VME_DATA_OE = oe_r;
  assign PCI_REQ = preq_r;
  assign PCI_ADDR = pci_r.addr;
  assign PCI_CMD = pci_r.cmd;
  assign PCI_BE_N = pci_r.be_n;
  assign LOCAL_IRQ = irq_r;
  assign VME_BR_N = br_r;
  assign MASTER_GRANTED = gnt_r;

endmodule : vsim_top
`default_nettype wire

/* File: core/vsim_regs.svh */
// Purpose: Offsets, field positions, reset values and codes of the inbound map
// Assumes: Offsets are byte offsets from the interface window base
// Notes: Definitions only
`ifndef VSIM_REGS_SVH
`define VSIM_REGS_SVH

// Register offsets on the local register port
`define VSIM_OFS_MATCH_MASK 12'h180
`define VSIM_OFS_BASE_MATCH 12'h184
`define VSIM_OFS_SG_INDEX 12'h188
`define VSIM_OFS_SG_DATA 12'h18c
`define VSIM_OFS_PAGE_CNT 12'h190
`define VSIM_OFS_BUS_ERR 12'h194
`define VSIM_OFS_IRQ_CTRL 12'h198
`define VSIM_OFS_ARB_CFG 12'h19c

// Reset values
`define VSIM_RST_WORD 32'h0000_0000
`define VSIM_RST_BYTE 8'h00

// Scatter-gather entry fields
`define VSIM_SG_VALID 5
`define VSIM_SG_WLOCK 9
`define VSIM_SG_SUPER 10
`define VSIM_SG_IOSEL 11
`define VSIM_SG_MON_HI 13
`define VSIM_SG_MON_LO 12
`define VSIM_SG_PAGE_HI 31
`define VSIM_SG_PAGE_LO 14

// Index register: table select bit, otherwise entry index
`define VSIM_IDX_A24_SEL 15

// Overflow flag in the bus error/status and interrupt control registers
`define VSIM_BESR_OVF 0
`define VSIM_ICR_OVF 0

// PCI bus commands; configuration codes are never generated
`define VSIM_CMD_IORD 4'h2
`define VSIM_CMD_IOWR 4'h3
`define VSIM_CMD_MEMRD 4'h6
`define VSIM_CMD_MEMWR 4'h7

// Address modifier decode
`define VSIM_AM_A32_TOP 3'h1
`define VSIM_AM_A24_TOP 3'h7
`define VSIM_AM_A16_USER 6'h29
`define VSIM_AM_A16_SUPER 6'h2d
`define VSIM_AM_SUPER_BIT 2

// Interprocessor byte register offsets in A16 space
`define VSIM_IPC_REV 8'h0b
`define VSIM_IPC_STAT 8'h0d
`define VSIM_IPC_WFLAG 8'h0f
`define VSIM_IPC_GP_LAST 3'h4

`endif

/* File: core/vsim_pkg.sv */
// Purpose: Types shared by the inbound map modules
// Assumes: Nothing beyond the register header
// Notes: Constants live in vsim_regs.svh
package vsim_pkg;

  // Slave cycle state, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_DECODE = 6'b000010,
    ST_CHECK = 6'b000100,
    ST_PCI = 6'b001000,
    ST_A16 = 6'b010000,
    ST_WAITEND = 6'b100000
  } vsim_state_t;

  // VMEbus pin bundle, synchronised as one vector
  typedef struct packed {
    logic [31:0] addr;
    logic [5:0] am;
    logic as_n;
    logic [1:0] ds_n;
    logic lword_n;
    logic write_n;
    logic [7:0] data;
  } vsim_vme_in_t;

  // PCI request towards the local bus
  typedef struct packed {
    logic [31:0] addr;
    logic [3:0] cmd;
    logic [3:0] be_n;
  } vsim_pci_req_t;

endpackage : vsim_pkg

/* File: core/vsim_space_match.sv */
// Purpose: Address space decode and base/mask compare for one slave cycle
// Assumes: Inputs are stable, registered copies of the VMEbus lines
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "vsim_regs.svh"
module vsim_space_match (
  input wire logic [31:0] addr,
  input wire logic [5:0] am,
  input wire logic [31:0] base,
  input wire logic [31:0] mask,
  output logic hit32,
  output logic hit24,
  output logic hit16,
  output logic super_cyc
);

  logic eq32;
  logic eq24;
  logic eq16;

  // Set mask bits drop the base bit from the compare; byte 0 is never looked at
  assign eq32 = ((addr[31:24] ^ base[31:24]) & ~mask[31:24]) == 8'h00;
  assign eq24 = ((addr[23:16] ^ base[23:16]) & ~mask[23:16]) == 8'h00;
  assign eq16 = ((addr[15:8] ^ base[15:8]) & ~mask[15:8]) == 8'h00;

  // Space from the address modifier; user-defined codes match nothing
  assign hit32 = eq32 && (am[5:3] == `VSIM_AM_A32_TOP);
  assign hit24 = eq24 && (am[5:3] == `VSIM_AM_A24_TOP);
  assign hit16 = eq16 && (am == `VSIM_AM_A16_USER || am == `VSIM_AM_A16_SUPER);
  assign super_cyc = am[`VSIM_AM_SUPER_BIT];

endmodule : vsim_space_match
`default_nettype wire

/* File: bench/vsim_top_chk.sv */
// Purpose: Port-level assertions for the inbound map
// Assumes: Bound to vsim_top; one clock domain
// Notes: Watches design ports only, both inputs and outputs
`timescale 1ns/1ps
`default_nettype none
module vsim_top_chk (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic VME_AS_N,
  input wire logic VME_LWORD_N,
  input wire logic VME_DTACK_N,
  input wire logic VME_BERR_N,
  input wire logic PCI_REQ,
  input wire logic [31:0] PCI_ADDR,
  input wire logic [3:0] PCI_CMD,
  input wire logic [3:0] PCI_BE_N,
  input wire logic PCI_ACK,
  input wire logic MASTER_WANT,
  input wire logic [3:0] VME_BR_N,
  input wire logic MASTER_GRANTED
);
  // Single domain, so clock and reset are given once
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  // PCI request shape
  chk_pci_top_low:
    assert property (PCI_REQ |-> PCI_ADDR[31] == 1'b0 && PCI_ADDR[1:0] == 2'b00) else $error("pci address pad");
  chk_no_config:
    assert property (PCI_REQ |-> PCI_CMD inside {4'h2, 4'h3, 4'h6, 4'h7}) else $error("pci command");
  chk_req_holds:
    assert property (PCI_REQ && !PCI_ACK |=> PCI_REQ && $stable(PCI_ADDR) && $stable(PCI_CMD) && $stable(PCI_BE_N))
      else $error("pci request moved");
  chk_lword_lanes:
    assert property (PCI_REQ && !VME_LWORD_N |-> PCI_BE_N == 4'h0) else $error("longword lanes");
  // Slave answer tied to PCI completion and refusal
  chk_ack_dtack:
    assert property (PCI_REQ && PCI_ACK |=> !PCI_REQ && !VME_DTACK_N) else $error("ack not answered");
  chk_berr_no_req:
    assert property (!VME_BERR_N |-> !PCI_REQ && VME_DTACK_N) else $error("refused cycle went out");
  chk_req_in_cycle:
    assert property (PCI_REQ |-> !VME_AS_N) else $error("request outside cycle");
  chk_resp_excl:
    assert property (VME_DTACK_N || VME_BERR_N) else $error("both answers");
  // Register read data only changes on a read
  chk_rdata_holds:
    assert property (!$past(REG_RD) |-> $stable(REG_RDATA)) else $error("read data moved");
  // Bus request
  chk_grant_release:
    assert property (MASTER_GRANTED |=> VME_BR_N == 4'hf) else $error("request kept");
  chk_grant_want:
    assert property (MASTER_GRANTED |-> $past(MASTER_WANT)) else $error("grant without want");
  chk_br_one_line:
    assert property (VME_BR_N != 4'hf |-> $onehot(~VME_BR_N)) else $error("request lines");
endmodule : vsim_top_chk

bind vsim_top vsim_top_chk u_chk (.CLOCK(CLOCK), .RST_N(RST_N), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .VME_AS_N(VME_AS_N), .VME_LWORD_N(VME_LWORD_N), .VME_DTACK_N(VME_DTACK_N), .VME_BERR_N(VME_BERR_N),
  .PCI_REQ(PCI_REQ), .PCI_ADDR(PCI_ADDR), .PCI_CMD(PCI_CMD), .PCI_BE_N(PCI_BE_N), .PCI_ACK(PCI_ACK),
  .MASTER_WANT(MASTER_WANT), .VME_BR_N(VME_BR_N), .MASTER_GRANTED(MASTER_GRANTED));
`default_nettype wire

/* File: bench/vsim_pci_model.sv */
// Purpose: Local PCI target answering inbound requests
// Assumes: Request holds until acknowledged
// Notes: Wait count set per scenario, so slow and prompt targets are both seen
`timescale 1ns/1ps
`default_nettype none
module vsim_pci_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic [31:0] addr,
  input wire logic [3:0] cmd,
  input wire logic [3:0] be_n,
  input wire logic [3:0] wait_cyc,
  output logic ack,
  output logic [39:0] last_req,
  output int req_count
);
  logic [3:0] wait_r;
  // One-cycle ack after the wait; the ack cycle itself never counts twice
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack <= 1'b0;
      wait_r <= 4'h0;
      req_count <= 0;
    end else if (req && !ack) begin
      if (wait_r == wait_cyc) begin
        ack <= 1'b1;
        last_req <= {addr, cmd, be_n};
        req_count <= req_count + 1;
        wait_r <= 4'h0;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end else begin
      ack <= 1'b0;
      wait_r <= 4'h0;
    end
  end
endmodule : vsim_pci_model
`default_nettype wire

/* File: bench/vsim_top_bench.sv */
// Purpose: Self-checking bench for the inbound map
// Assumes: Small tables (64/32 entries); VME lines held while strobe low
// Notes: PCI side answered by vsim_pci_model
`timescale 1ns/1ps
`default_nettype none
module vsim_top_bench;
  logic CLOCK, RST_N, REG_WR, REG_RD, VME_AS_N, VME_LWORD_N, VME_WRITE_N, MASTER_WANT, VME_BG_N;
  logic [11:0] REG_ADDR;
  logic [31:0] REG_WDATA, VME_ADDR, REG_RDATA, PCI_ADDR;
  logic [5:0] VME_AM;
  logic [1:0] VME_DS_N;
  logic [7:0] VME_DATA_IN, VME_DATA_OUT;
  logic VME_DTACK_N, VME_BERR_N, VME_DATA_OE, PCI_REQ, PCI_ACK, LOCAL_IRQ, MASTER_GRANTED;
  logic [3:0] PCI_CMD, PCI_BE_N, VME_BR_N, pci_wait;
  logic [39:0] pci_last;
  int pci_count, fail_count, checks_done, cycles;

  vsim_top #(.A32_ENTRIES(64), .A24_ENTRIES(32), .IPC_REVISION(8'h5a)) u_dut ( // Revision value arbitrary
    .CLOCK(CLOCK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .VME_ADDR(VME_ADDR), .VME_AM(VME_AM), .VME_AS_N(VME_AS_N),
    .VME_DS_N(VME_DS_N), .VME_LWORD_N(VME_LWORD_N), .VME_WRITE_N(VME_WRITE_N), .VME_DATA_IN(VME_DATA_IN),
    .VME_DTACK_N(VME_DTACK_N), .VME_BERR_N(VME_BERR_N), .VME_DATA_OUT(VME_DATA_OUT), .VME_DATA_OE(VME_DATA_OE),
    .PCI_REQ(PCI_REQ), .PCI_ADDR(PCI_ADDR), .PCI_CMD(PCI_CMD), .PCI_BE_N(PCI_BE_N), .PCI_ACK(PCI_ACK),
    .LOCAL_IRQ(LOCAL_IRQ), .MASTER_WANT(MASTER_WANT), .VME_BG_N(VME_BG_N), .VME_BR_N(VME_BR_N),
    .MASTER_GRANTED(MASTER_GRANTED));
  vsim_pci_model u_pci (.clk(CLOCK), .rst_n(RST_N), .req(PCI_REQ), .addr(PCI_ADDR), .cmd(PCI_CMD),
    .be_n(PCI_BE_N), .wait_cyc(pci_wait), .ack(PCI_ACK), .last_req(pci_last), .req_count(pci_count));

  // 20 MHz clock
  initial begin
    CLOCK = 1'b0;
    forever #25 CLOCK = ~CLOCK;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  // Hang guard, far above the several hundred cycles the run needs
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Strobe for one cycle; the idle edge after it keeps back-to-back calls apart
  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLOCK);
    REG_WR <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLOCK);
    REG_RD <= 1'b0;
    @(posedge CLOCK);
    #1;
    d = REG_RDATA;
  endtask : reg_rd

  function automatic logic [31:0] ent(input logic [17:0] pg, input logic [1:0] mon, input logic io,
      input logic sup, input logic wl, input logic v);
    ent = {pg, mon, io, sup, wl, 3'b000, v, 5'b00000};
  endfunction : ent

  task automatic set_entry(input logic a24, input logic [14:0] idx, input logic [31:0] e);
    reg_wr(12'h188, {16'h0000, a24, idx});
    reg_wr(12'h18c, e);
  endtask : set_entry

  // One slave cycle; resp 0 ack, 1 bus error, 2 no answer. Released lines show inverted values
  task automatic vme(input logic [31:0] a, input logic [5:0] am, input logic wr, input logic lw,
      input logic [1:0] ds, input logic [7:0] d, output logic [1:0] resp, output logic [7:0] rd);
    int n;
    @(posedge CLOCK);
    VME_ADDR <= a;
    VME_AM <= am;
    VME_WRITE_N <= !wr;
    VME_LWORD_N <= !lw;
    VME_DS_N <= ds;
    VME_DATA_IN <= d;
    @(posedge CLOCK);
    VME_AS_N <= 1'b0;
    resp = 2'd2;
    for (n = 0; n < 60 && resp == 2'd2; n++) begin
      @(posedge CLOCK);
      #1;
      if (VME_DTACK_N === 1'b0) resp = 2'd0;
      else if (VME_BERR_N === 1'b0) resp = 2'd1;
    end
    rd = VME_DATA_OE ? VME_DATA_OUT : ~VME_DATA_OUT;
    @(posedge CLOCK);
    VME_AS_N <= 1'b1;
    VME_DS_N <= 2'b11;
    VME_ADDR <= ~a;
    VME_DATA_IN <= ~d;
    repeat (6) @(posedge CLOCK);
  endtask : vme

  task automatic t_regs();
    logic [11:0] ofs [7] = '{12'h180, 12'h184, 12'h188, 12'h190, 12'h194, 12'h198, 12'h19c};
    logic [31:0] r;
    for (int i = 0; i < 7; i++) begin
      reg_rd(ofs[i], r);
      chk(r, 32'h0000_0000);
    end
    reg_wr(12'h1a0, 32'hffff_ffff);
    reg_rd(12'h1a0, r);
    chk(r, 32'h0000_0000);
    reg_wr(12'h180, 32'h0000_00ff);
    reg_wr(12'h184, 32'h4020_12ff);
    reg_rd(12'h184, r);
    chk(r, 32'h4020_12ff);
  endtask : t_regs

  // Memory and I/O, read and write, prompt and slow target, both lane codings
  task automatic t_a32();
    logic [1:0] rs;
    logic [7:0] rd;
    logic [31:0] a;
    int n0;
    for (int k = 0; k < 4; k++) begin
      pci_wait <= 4'(k * 3);
      set_entry(1'b0, 15'd3, ent(18'h2abcd, 2'd0, k[1], 1'b0, 1'b0, 1'b1));
      a = 32'h4000_7ffc ^ 32'(k << 8) ^ 32'(k % 2 * 2);
      n0 = pci_count;
      vme(a, 6'h09, k[0], !k[0], k[0] ? 2'b10 : 2'b00, 8'h00, rs, rd);
      chk({30'h0, rs}, 32'h0);
      chk(32'(pci_count - n0), 32'h1);
      chk(pci_last[39:8], {1'b0, 18'h2abcd, a[12:2], 2'b00});
      chk({24'h0, pci_last[7:0]}, {24'h0, k[1] ? {3'b001, k[0]} : {3'b011, k[0]}, k[0] ? 4'h7 : 4'h0});
    end
    set_entry(1'b1, 15'd2, ent(18'h01234, 2'd3, 1'b0, 1'b0, 1'b0, 1'b1));
    vme(32'h0020_4010, 6'h39, 1'b0, 1'b1, 2'b00, 8'h00, rs, rd);
    chk({30'h0, rs}, 32'h0);
    chk(pci_last[39:8], {1'b0, 18'h01234, 11'h004, 2'b00});
    reg_rd(12'h18c, a);
    chk(a, 32'h048d_3020);
  endtask : t_a32

  task automatic try(input logic [31:0] e, input logic [31:0] a, input logic [5:0] am, input logic wr,
      input logic [1:0] exp);
    logic [1:0] rs;
    logic [7:0] rd;
    int n0;
    set_entry(1'b0, 15'd5, e);
    n0 = pci_count;
    vme(a, am, wr, 1'b1, 2'b00, 8'h00, rs, rd);
    chk({30'h0, rs}, {30'h0, exp});
    chk(32'(pci_count - n0), exp == 2'd0 ? 32'h1 : 32'h0);
  endtask : try

  task automatic t_refuse();
    pci_wait <= 4'd1;
    try(ent(18'h1, 2'd1, 1'b0, 1'b0, 1'b0, 1'b0), 32'h4000_a000, 6'h09, 1'b0, 2'd1);
    try(ent(18'h1, 2'd1, 1'b0, 1'b0, 1'b1, 1'b1), 32'h4000_a004, 6'h09, 1'b1, 2'd1);
    try(ent(18'h1, 2'd1, 1'b0, 1'b0, 1'b1, 1'b1), 32'h4000_a008, 6'h09, 1'b0, 2'd0);
    try(ent(18'h1, 2'd1, 1'b0, 1'b1, 1'b0, 1'b1), 32'h4000_a00c, 6'h09, 1'b0, 2'd1);
    try(ent(18'h1, 2'd1, 1'b0, 1'b1, 1'b0, 1'b1), 32'h4000_a010, 6'h0d, 1'b0, 2'd0);
    try(ent(18'h1, 2'd0, 1'b0, 1'b0, 1'b0, 1'b1), 32'h4100_a000, 6'h09, 1'b0, 2'd2);
    reg_wr(12'h180, 32'h0100_00ff);
    try(ent(18'h1, 2'd0, 1'b0, 1'b0, 1'b0, 1'b1), 32'h4100_a000, 6'h09, 1'b0, 2'd0);
    reg_wr(12'h180, 32'h0000_00ff);
  endtask : t_refuse

  task automatic t_a16();
    logic [1:0] rs;
    logic [7:0] rd;
    vme(32'h0000_1203, 6'h29, 1'b1, 1'b0, 2'b10, 8'ha5, rs, rd);
    chk({30'h0, rs}, 32'h0);
    vme(32'h0000_1203, 6'h29, 1'b0, 1'b0, 2'b10, 8'h00, rs, rd);
    chk({24'h0, rd}, 32'h0000_00a5);
    vme(32'h0000_120b, 6'h2d, 1'b0, 1'b0, 2'b10, 8'h00, rs, rd);
    chk({24'h0, rd}, 32'h0000_005a);
    vme(32'h0000_120f, 6'h29, 1'b0, 1'b0, 2'b10, 8'h00, rs, rd);
    chk({24'h0, rd}, 32'h0000_0002);
  endtask : t_a16

  // Eight bumps wrap monitor 2; monitor 1 holds the two accepted refusal-test hits, monitor 3 one
  task automatic t_mon();
    logic [1:0] rs;
    logic [7:0] rd;
    logic [31:0] r;
    set_entry(1'b0, 15'd6, ent(18'h3, 2'd2, 1'b0, 1'b0, 1'b0, 1'b1));
    for (int k = 0; k < 8; k++) vme(32'h4000_c000, 6'h09, 1'b0, 1'b1, 2'b00, 8'h00, rs, rd);
    reg_rd(12'h190, r);
    chk(r, 32'h0000_0182);
    reg_rd(12'h194, r);
    chk(r, 32'h0000_0001);
    chk({31'h0, LOCAL_IRQ}, 32'h0);
    reg_wr(12'h198, 32'h0000_0001);
    repeat (3) @(posedge CLOCK);
    #1;
    chk({31'h0, LOCAL_IRQ}, 32'h1);
    reg_wr(12'h190, 32'h0000_0080);
    reg_wr(12'h194, 32'h0000_0001);
    reg_rd(12'h190, r);
    chk(r, 32'h0000_0102);
    chk({31'h0, LOCAL_IRQ}, 32'h0);
  endtask : t_mon

  task automatic t_master();
    reg_wr(12'h19c, 32'h0000_0002);
    @(posedge CLOCK);
    MASTER_WANT <= 1'b1;
    repeat (4) @(posedge CLOCK);
    #1;
    chk({28'h0, VME_BR_N}, 32'h0000_000b);
    chk({31'h0, MASTER_GRANTED}, 32'h0);
    @(posedge CLOCK);
    VME_BG_N <= 1'b0;
    repeat (6) @(posedge CLOCK);
    #1;
    chk({28'h0, VME_BR_N}, 32'h0000_000f);
    chk({31'h0, MASTER_GRANTED}, 32'h1);
    @(posedge CLOCK);
    MASTER_WANT <= 1'b0;
    VME_BG_N <= 1'b1;
  endtask : t_master

  // Main sequence
  initial begin
    RST_N = 1'b0;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = 12'h000;
    REG_WDATA = 32'h0000_0000;
    VME_ADDR = 32'h0000_0000;
    VME_AM = 6'h00;
    VME_AS_N = 1'b1;
    VME_DS_N = 2'b11;
    VME_LWORD_N = 1'b1;
    VME_WRITE_N = 1'b1;
    VME_DATA_IN = 8'h00;
    MASTER_WANT = 1'b0;
    VME_BG_N = 1'b1;
    pci_wait = 4'h0;
    repeat (20) @(posedge CLOCK);
    RST_N <= 1'b1;
    repeat (4) @(posedge CLOCK);
    t_regs();
    t_a32();
    t_refuse();
    t_a16();
    t_mon();
    t_master();
    end_of_test();
  end
endmodule : vsim_top_bench
`default_nettype wire
